/* File: dv/host_port_model.sv */
`timescale 1ns/1ps
// Stand-in for the host on the register port; one access at a time, driven off the falling edge.
module host_port_model (
	input wire logic clock,
	input wire logic [7:0] reg_rdata,
	output logic [9:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata
);
	// Idle values at time zero.
	initial begin
		reg_addr = 10'h3ff;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end

	// Released lines show the inverse, so a stale address or data is never reused by chance.
	task automatic write_reg(input logic [9:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	// Read data is registered on the rising edge half a cycle after the strobe edge, so it is settled here.
	task automatic read_reg(input logic [9:0] a, output logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule

/* File: dv/radio_aux_control_status_regs_tb.sv */
`timescale 1ns/1ps
module radio_aux_control_status_regs_tb;
	import aux_regs_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [9:0] reg_addr;
	logic reg_wr, reg_rd;
	logic [7:0] reg_wdata, reg_rdata, converter_result, smart_wake_strength;
	logic [7:0] smart_wake_strength_limit;
	logic [4:0] battery_trip_code, supply_level_code;
	logic [15:0] wake_count, wake_count_limit, ev;
	logic converter_power_on, strength_detector_power_on, if_filter_power_on, mixer_power_on;
	logic front_amp_power_on, temperature_monitor_on, battery_monitor_on, external_clock_out;
	logic gain_update_tick, smart_wake_active, cipher_loaded, packet_mode, synth_tune_enable;
	logic filter_tune_enable, synth_tune_done, filter_tune_done, amp_ramp_done;
	int err_total = 0;
	int checked = 0;
	// Bench model of every register's expected contents, keyed by offset.
	int exp_reg [int];
	logic [9:0] map_list [$] = '{ADDR_RX_POWER, ADDR_AUX_POWER, ADDR_CONV_HIGH, ADDR_CONV_LOW,
		ADDR_BATT_TRIP, ADDR_EXT_CLK_DIV, ADDR_GAIN_CLK_DIV, ADDR_RADIO_FLAGS,
		ADDR_SYSTEM_FLAGS, ADDR_CAL_ENABLES, ADDR_CAL_READY, 10'h326, 10'h33a};
	logic [9:0] cfg_list [$] = '{ADDR_RX_POWER, ADDR_AUX_POWER, ADDR_BATT_TRIP,
		ADDR_EXT_CLK_DIV, ADDR_GAIN_CLK_DIV, ADDR_CAL_ENABLES};
	int cfg_mask [$] = '{'h1f, 'h03, 'h1f, 'h0f, 'hff, 'h03};
	int ev_list [$] = '{0, 1, 2, 3, 4, 5, 8, 9, 12, 14};
	int div_list [$] = '{0, 1, 4, 7};

	// Free-running 100 MHz clock.
	always #5 clock = ~clock;

	radio_aux_control_status_regs dut_u (
		.clock, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.converter_power_on, .strength_detector_power_on, .if_filter_power_on,
		.mixer_power_on, .front_amp_power_on, .temperature_monitor_on, .battery_monitor_on,
		.battery_trip_code, .converter_result, .supply_level_code, .external_clock_out,
		.gain_update_tick, .wake_count, .wake_count_limit, .smart_wake_active,
		.smart_wake_strength, .smart_wake_strength_limit, .cipher_loaded,
		.cipher_done(ev[5]), .packet_mode, .tx_end(ev[4]), .addr_match(ev[3]),
		.crc_good(ev[2]), .sync_seen(ev[1]), .preamble_seen(ev[0]), .cmd_ready(ev[14]),
		.cmd_finished(ev[8]), .wake_timer_expired(ev[12]), .port_ready(ev[9]),
		.synth_tune_enable, .filter_tune_enable, .synth_tune_done, .filter_tune_done,
		.amp_ramp_done
	);

	host_port_model host_u (.clock, .reg_rdata, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Reads one register and compares it with the model.
	task automatic read_chk(input logic [9:0] a);
		logic [7:0] d;
		host_u.read_reg(a, d);
		check($sformatf("reg %h", a), {8'h00, d}, 16'(exp_reg[a]));
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// A hang is cut short well past the few thousand cycles the tests need.
	initial begin
		#200000;
		err_total++;
		$display("Error watchdog expected finish seen hang");
		print_verdict();
	end

	initial begin
		logic [9:0] a;
		int n, hi, tk;
		ev = 16'h0000;
		converter_result = 8'h00;
		supply_level_code = 5'h1f;
		wake_count = 16'h0000;
		wake_count_limit = 16'hffff;
		smart_wake_active = 1'b0;
		smart_wake_strength = 8'h00;
		smart_wake_strength_limit = 8'hff;
		cipher_loaded = 1'b1;
		packet_mode = 1'b1;
		synth_tune_done = 1'b0;
		filter_tune_done = 1'b0;
		amp_ramp_done = 1'b0;
		foreach (map_list[i]) exp_reg[map_list[i]] = 0;
		exp_reg[ADDR_EXT_CLK_DIV] = 'h04;
		exp_reg[ADDR_GAIN_CLK_DIV] = 'h28;
		void'($urandom(32'ha9c239b5));
		repeat (12) @(negedge clock);
		rst_n = 1'b1;
		foreach (map_list[i]) read_chk(map_list[i]);
		$display("reset values done");

		// Random settings, then writes to unmapped and read-only places.
		foreach (cfg_list[i]) begin
			n = $urandom;
			host_u.write_reg(cfg_list[i], 8'(n));
			exp_reg[cfg_list[i]] = n & cfg_mask[i];
			read_chk(cfg_list[i]);
		end
		check("rx power", 16'({converter_power_on, strength_detector_power_on,
			if_filter_power_on, mixer_power_on, front_amp_power_on}),
			16'(exp_reg[ADDR_RX_POWER]));
		check("aux power", 16'({temperature_monitor_on, battery_monitor_on}),
			16'(exp_reg[ADDR_AUX_POWER]));
		check("trip code", 16'(battery_trip_code), 16'(exp_reg[ADDR_BATT_TRIP]));
		check("tune", 16'({synth_tune_enable, filter_tune_enable}),
			16'(exp_reg[ADDR_CAL_ENABLES]));
		foreach (map_list[i]) if (i == 2 || i > 9) host_u.write_reg(map_list[i], 8'hff);
		foreach (map_list[i]) if (i == 2 || i > 9) read_chk(map_list[i]);
		$display("settings done");

		// Converter value split across two read-only registers.
		converter_result = 8'($urandom);
		exp_reg[ADDR_CONV_HIGH] = converter_result >> 2;
		exp_reg[ADDR_CONV_LOW] = {converter_result[1:0], 6'h00};
		read_chk(ADDR_CONV_HIGH);
		read_chk(ADDR_CONV_LOW);
		synth_tune_done = 1'b1;
		filter_tune_done = 1'b1;
		amp_ramp_done = 1'b1;
		for (int e = 0; e < 2; e++) begin
			host_u.write_reg(ADDR_CAL_ENABLES, 8'(e));
			exp_reg[ADDR_CAL_READY] = 6 | e;
			read_chk(ADDR_CAL_READY);
		end
		$display("readback done");

		// Every pulse source; writing ones elsewhere keeps the flag, its own one clears it.
		foreach (ev_list[i]) begin
			a = ev_list[i] < 8 ? ADDR_RADIO_FLAGS : ADDR_SYSTEM_FLAGS;
			@(negedge clock);
			ev[ev_list[i]] = 1'b1;
			@(negedge clock);
			ev[ev_list[i]] = 1'b0;
			exp_reg[a] = 1 << (ev_list[i] % 8);
			host_u.write_reg(a, ~8'(exp_reg[a]));
			read_chk(a);
			host_u.write_reg(a, 8'(exp_reg[a]));
			exp_reg[a] = 0;
			read_chk(a);
		end
		cipher_loaded = 1'b0;
		packet_mode = 1'b0;
		@(negedge clock);
		ev = 16'h003c;
		@(negedge clock);
		ev = 16'h0000;
		read_chk(ADDR_RADIO_FLAGS);
		// A preamble pulse in the very cycle the host clears that bit must survive.
		fork
			host_u.write_reg(ADDR_RADIO_FLAGS, 8'h01);
			begin
				@(negedge clock);
				ev[0] = 1'b1;
				@(negedge clock);
				ev[0] = 1'b0;
			end
		join
		exp_reg[ADDR_RADIO_FLAGS] = 'h01;
		read_chk(ADDR_RADIO_FLAGS);
		host_u.write_reg(ADDR_RADIO_FLAGS, 8'h01);
		exp_reg[ADDR_RADIO_FLAGS] = 0;
		read_chk(ADDR_RADIO_FLAGS);
		$display("event flags done");

		// Level conditions: wake count, smart-wake strength and battery alarm.
		wake_count_limit = 16'h0005;
		wake_count = 16'h0005;
		smart_wake_strength = 8'h81;
		smart_wake_strength_limit = 8'h80;
		smart_wake_active = 1'b1;
		exp_reg[ADDR_RADIO_FLAGS] = 'hc0;
		read_chk(ADDR_RADIO_FLAGS);
		host_u.write_reg(ADDR_RADIO_FLAGS, 8'hc0);
		exp_reg[ADDR_RADIO_FLAGS] = 0;
		read_chk(ADDR_RADIO_FLAGS);
		host_u.write_reg(ADDR_AUX_POWER, 8'h01);
		host_u.write_reg(ADDR_BATT_TRIP, 8'h0a);
		supply_level_code = 5'h0a;
		repeat (5) @(negedge clock);
		read_chk(ADDR_SYSTEM_FLAGS);
		supply_level_code = 5'h09;
		repeat (5) @(negedge clock);
		exp_reg[ADDR_SYSTEM_FLAGS] = 'h80;
		read_chk(ADDR_SYSTEM_FLAGS);
		$display("level flags done");

		// Divided clock and gain tick over a window that is a whole number of periods.
		foreach (div_list[i]) begin
			n = div_list[i];
			host_u.write_reg(ADDR_EXT_CLK_DIV, 8'(n));
			host_u.write_reg(ADDR_GAIN_CLK_DIV, 8'(n));
			repeat (2) @(negedge clock);
			hi = 0;
			tk = 0;
			repeat (448) begin
				@(negedge clock);
				hi += external_clock_out;
				tk += gain_update_tick;
			end
			check("ext high", 16'(hi), 16'(n == 1 ? 224 : n == 0 ? 0 : 448 / n * (n / 2)));
			check("gain ticks", 16'(tk), 16'(n == 0 ? 0 : 448 / (16 * n)));
		end
		$display("clock outputs done");
		print_verdict();
	end
endmodule

/* File: verilog/aux_regs_pkg.sv */
package aux_regs_pkg;

	// Register offsets on the device's register port.
	localparam logic [9:0] ADDR_RX_POWER = 10'h324;
	localparam logic [9:0] ADDR_AUX_POWER = 10'h325;
	localparam logic [9:0] ADDR_CONV_HIGH = 10'h327;
	localparam logic [9:0] ADDR_CONV_LOW = 10'h328;
	localparam logic [9:0] ADDR_BATT_TRIP = 10'h32d;
	localparam logic [9:0] ADDR_EXT_CLK_DIV = 10'h32e;
	localparam logic [9:0] ADDR_GAIN_CLK_DIV = 10'h32f;
	localparam logic [9:0] ADDR_RADIO_FLAGS = 10'h336;
	localparam logic [9:0] ADDR_SYSTEM_FLAGS = 10'h337;
	localparam logic [9:0] ADDR_CAL_ENABLES = 10'h338;
	localparam logic [9:0] ADDR_CAL_READY = 10'h339;

	// Reset values.
	localparam logic [7:0] RST_RX_POWER = 8'h00;
	localparam logic [7:0] RST_AUX_POWER = 8'h00;
	localparam logic [7:0] RST_BATT_TRIP = 8'h00;
	localparam logic [7:0] RST_EXT_CLK_DIV = 8'h04;
	localparam logic [7:0] RST_GAIN_CLK_DIV = 8'h28;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_CAL_ENABLES = 8'h00;

	// Writable field masks; bits outside read back as zero.
	localparam logic [7:0] MASK_RX_POWER = 8'h1f;
	localparam logic [7:0] MASK_AUX_POWER = 8'h03;
	localparam logic [7:0] MASK_BATT_TRIP = 8'h1f;
	localparam logic [7:0] MASK_EXT_CLK_DIV = 8'h0f;
	localparam logic [7:0] MASK_CAL_ENABLES = 8'h03;
	localparam logic [7:0] MASK_SYSTEM_FLAGS = 8'hd3;

	// Field positions.
	localparam int BIT_CONV_ON = 4;
	localparam int BIT_DET_ON = 3;
	localparam int BIT_FILT_ON = 2;
	localparam int BIT_MIX_ON = 1;
	localparam int BIT_AMP_ON = 0;
	localparam int BIT_TEMP_ON = 1;
	localparam int BIT_BATT_ON = 0;
	localparam int BIT_SYNTH_TUNE = 1;
	localparam int BIT_FILTER_TUNE = 0;
	localparam int BIT_RAMP_DONE = 2;
	localparam int BIT_BATT_ALARM = 7;
	localparam int BIT_CMD_READY = 6;
	localparam int BIT_WAKE_TIMER = 4;
	localparam int BIT_PORT_READY = 1;
	localparam int BIT_CMD_DONE = 0;
	localparam int BIT_WAKE_COUNT = 7;
	localparam int BIT_SW_STRENGTH = 6;
	localparam int BIT_CIPHER_DONE = 5;
	localparam int BIT_TX_END = 4;
	localparam int BIT_ADDR_MATCH = 3;
	localparam int BIT_CRC_GOOD = 2;
	localparam int BIT_SYNC_SEEN = 1;
	localparam int BIT_PREAMBLE_SEEN = 0;

	// The gain-control tick period is this factor times the divider value.
	localparam int GAIN_PRESCALE = 16;
	localparam int GAIN_CNT_W = 12;

endpackage

/* File: verilog/radio_aux_control_status_regs.sv */
`timescale 1ns/1ps
module radio_aux_control_status_regs
	import aux_regs_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [9:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic converter_power_on,
	output logic strength_detector_power_on,
	output logic if_filter_power_on,
	output logic mixer_power_on,
	output logic front_amp_power_on,
	output logic temperature_monitor_on,
	output logic battery_monitor_on,
	output logic [4:0] battery_trip_code,
	input wire logic [7:0] converter_result,
	input wire logic [4:0] supply_level_code,
	output logic external_clock_out,
	output logic gain_update_tick,
	input wire logic [15:0] wake_count,
	input wire logic [15:0] wake_count_limit,
	input wire logic smart_wake_active,
	input wire logic [7:0] smart_wake_strength,
	input wire logic [7:0] smart_wake_strength_limit,
	input wire logic cipher_loaded,
	input wire logic cipher_done,
	input wire logic packet_mode,
	input wire logic tx_end,
	input wire logic addr_match,
	input wire logic crc_good,
	input wire logic sync_seen,
	input wire logic preamble_seen,
	input wire logic cmd_ready,
	input wire logic cmd_finished,
	input wire logic wake_timer_expired,
	input wire logic port_ready,
	output logic synth_tune_enable,
	output logic filter_tune_enable,
	input wire logic synth_tune_done,
	input wire logic filter_tune_done,
	input wire logic amp_ramp_done
);

	logic [7:0] rx_power_q;
	logic [7:0] aux_power_q;
	logic [7:0] batt_trip_q;
	logic [7:0] ext_div_q;
	logic [7:0] gain_div_q;
	logic [7:0] cal_en_q;
	logic [7:0] radio_flags_q;
	logic [7:0] radio_flags_d;
	logic [7:0] system_flags_q;
	logic [7:0] system_flags_d;
	logic [7:0] cal_ready_q;
	logic [7:0] conv_q;
	logic [7:0] rdata_d;
	logic [4:0] supply_meta_q;
	logic [4:0] supply_q;
	logic below_q;
	logic wake_reached_q;
	logic strength_over_q;
	logic [3:0] ext_cnt_q;
	logic [3:0] ext_cnt_d;
	logic ext_out_q;
	logic ext_out_d;
	logic [GAIN_CNT_W-1:0] gain_cnt_q;
	logic [GAIN_CNT_W-1:0] gain_cnt_d;
	logic gain_tick_q;

	// Write decode.
	wire wr_rx = reg_wr && (reg_addr == ADDR_RX_POWER);
	wire wr_aux = reg_wr && (reg_addr == ADDR_AUX_POWER);
	wire wr_trip = reg_wr && (reg_addr == ADDR_BATT_TRIP);
	wire wr_ext = reg_wr && (reg_addr == ADDR_EXT_CLK_DIV);
	wire wr_gain = reg_wr && (reg_addr == ADDR_GAIN_CLK_DIV);
	wire wr_radio = reg_wr && (reg_addr == ADDR_RADIO_FLAGS);
	wire wr_system = reg_wr && (reg_addr == ADDR_SYSTEM_FLAGS);
	wire wr_cal = reg_wr && (reg_addr == ADDR_CAL_ENABLES);

	// Control registers; reserved bits are masked so they always read zero.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rx_power_q <= RST_RX_POWER;
			aux_power_q <= RST_AUX_POWER;
			batt_trip_q <= RST_BATT_TRIP;
			ext_div_q <= RST_EXT_CLK_DIV;
			gain_div_q <= RST_GAIN_CLK_DIV;
			cal_en_q <= RST_CAL_ENABLES;
		end else begin
			if (wr_rx) rx_power_q <= reg_wdata & MASK_RX_POWER;
			if (wr_aux) aux_power_q <= reg_wdata & MASK_AUX_POWER;
			if (wr_trip) batt_trip_q <= reg_wdata & MASK_BATT_TRIP;
			if (wr_ext) ext_div_q <= reg_wdata & MASK_EXT_CLK_DIV;
			if (wr_gain) gain_div_q <= reg_wdata;
			if (wr_cal) cal_en_q <= reg_wdata & MASK_CAL_ENABLES;
		end
	end

	// Enable bits drive the analogue blocks directly.
	assign converter_power_on = rx_power_q[BIT_CONV_ON];
	assign strength_detector_power_on = rx_power_q[BIT_DET_ON];
	assign if_filter_power_on = rx_power_q[BIT_FILT_ON];
	assign mixer_power_on = rx_power_q[BIT_MIX_ON];
	assign front_amp_power_on = rx_power_q[BIT_AMP_ON];
	assign temperature_monitor_on = aux_power_q[BIT_TEMP_ON];
	assign battery_monitor_on = aux_power_q[BIT_BATT_ON];
	assign battery_trip_code = batt_trip_q[4:0];
	assign synth_tune_enable = cal_en_q[BIT_SYNTH_TUNE];
	assign filter_tune_enable = cal_en_q[BIT_FILTER_TUNE];

	// The supply code comes from the analogue monitor in the same 62 mV steps
	// above 1.7 V as the trip code, so comparing codes compares voltages.
	// It is asynchronous, so it passes two flops first.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			supply_meta_q <= 5'h00;
			supply_q <= 5'h00;
		end else begin
			supply_meta_q <= supply_level_code;
			supply_q <= supply_meta_q;
		end
	end

	// Level conditions; flags are raised on their rising edge only, so a
	// lasting condition does not re-set a flag the host has just cleared.
	wire below_now = battery_monitor_on && (supply_q < batt_trip_q[4:0]);
	wire wake_reached_now = (wake_count >= wake_count_limit);
	wire strength_over_now = smart_wake_active
		&& (smart_wake_strength > smart_wake_strength_limit);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			below_q <= 1'b0;
			wake_reached_q <= 1'b0;
			strength_over_q <= 1'b0;
		end else begin
			below_q <= below_now;
			wake_reached_q <= wake_reached_now;
			strength_over_q <= strength_over_now;
		end
	end

	// Event sets for each flag bit.
	wire [7:0] radio_set;
	wire [7:0] system_set;
	assign radio_set[BIT_WAKE_COUNT] = wake_reached_now && !wake_reached_q;
	assign radio_set[BIT_SW_STRENGTH] = strength_over_now && !strength_over_q;
	assign radio_set[BIT_CIPHER_DONE] = cipher_done && cipher_loaded;
	assign radio_set[BIT_TX_END] = tx_end && packet_mode;
	assign radio_set[BIT_ADDR_MATCH] = addr_match && packet_mode;
	assign radio_set[BIT_CRC_GOOD] = crc_good && packet_mode;
	assign radio_set[BIT_SYNC_SEEN] = sync_seen;
	assign radio_set[BIT_PREAMBLE_SEEN] = preamble_seen;
	assign system_set[BIT_BATT_ALARM] = below_now && !below_q;
	assign system_set[BIT_CMD_READY] = cmd_ready;
	assign system_set[5] = 1'b0;
	assign system_set[BIT_WAKE_TIMER] = wake_timer_expired;
	assign system_set[3] = 1'b0;
	assign system_set[2] = 1'b0;
	assign system_set[BIT_PORT_READY] = port_ready;
	assign system_set[BIT_CMD_DONE] = cmd_finished;

	// Writing a one clears a flag; a set arriving in the same cycle wins so
	// that no event is lost.
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_flag
			assign radio_flags_d[gi] = radio_set[gi]
				|| (radio_flags_q[gi] && !(wr_radio && reg_wdata[gi]));
			assign system_flags_d[gi] = MASK_SYSTEM_FLAGS[gi] && (system_set[gi]
				|| (system_flags_q[gi] && !(wr_system && reg_wdata[gi])));
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			radio_flags_q <= RST_FLAGS;
			system_flags_q <= RST_FLAGS;
		end else begin
			radio_flags_q <= radio_flags_d;
			system_flags_q <= system_flags_d;
		end
	end

	// Calibration status and converter sample; status comes from same-clock
	// calibration logic, so no synchroniser.
	wire [7:0] cal_ready_d = {5'h00, amp_ramp_done, synth_tune_done,
		filter_tune_done && filter_tune_enable};

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cal_ready_q <= 8'h00;
			conv_q <= 8'h00;
		end else begin
			cal_ready_q <= cal_ready_d;
			conv_q <= converter_result;
		end
	end

	// External clock divider: high for the first half of each period. A
	// ratio of one cannot be made from this clock, so it toggles instead,
	// giving half the clock rate.
	wire [3:0] ext_ratio = ext_div_q[3:0];
	wire ext_wrap = (ext_cnt_q >= ext_ratio - 4'h1);
	assign ext_cnt_d = (ext_ratio == 4'h0 || ext_wrap) ? 4'h0 : ext_cnt_q + 4'h1;
	assign ext_out_d = (ext_ratio == 4'h0) ? 1'b0 :
		(ext_ratio == 4'h1) ? !ext_out_q : (ext_cnt_d < {1'b0, ext_ratio[3:1]});

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ext_cnt_q <= 4'h0;
			ext_out_q <= 1'b0;
		end else begin
			ext_cnt_q <= ext_cnt_d;
			ext_out_q <= ext_out_d;
		end
	end

	assign external_clock_out = ext_out_q;

	// Gain-control tick: one pulse per prescale times divider clocks. A
	// divider of zero stops the tick rather than dividing by zero.
	wire [GAIN_CNT_W-1:0] gain_period = GAIN_CNT_W'(GAIN_PRESCALE * gain_div_q);
	wire gain_wrap = (gain_cnt_q >= gain_period - GAIN_CNT_W'(1));
	assign gain_cnt_d = (gain_div_q == 8'h00 || gain_wrap) ?
		'0 : gain_cnt_q + GAIN_CNT_W'(1);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			gain_cnt_q <= '0;
			gain_tick_q <= 1'b0;
		end else begin
			gain_cnt_q <= gain_cnt_d;
			gain_tick_q <= (gain_div_q != 8'h00) && gain_wrap;
		end
	end

	assign gain_update_tick = gain_tick_q;

	// Read multiplexer; unmapped offsets read zero.
	always_comb begin
		rdata_d = 8'h00;
		unique case (reg_addr)
			ADDR_RX_POWER: rdata_d = rx_power_q;
			ADDR_AUX_POWER: rdata_d = aux_power_q;
			ADDR_CONV_HIGH: rdata_d = {2'b00, conv_q[7:2]};
			ADDR_CONV_LOW: rdata_d = {conv_q[1:0], 6'h00};
			ADDR_BATT_TRIP: rdata_d = batt_trip_q;
			ADDR_EXT_CLK_DIV: rdata_d = ext_div_q;
			ADDR_GAIN_CLK_DIV: rdata_d = gain_div_q;
			ADDR_RADIO_FLAGS: rdata_d = radio_flags_q;
			ADDR_SYSTEM_FLAGS: rdata_d = system_flags_q;
			ADDR_CAL_ENABLES: rdata_d = cal_en_q;
			ADDR_CAL_READY: rdata_d = cal_ready_q;
			default: rdata_d = 8'h00;
		endcase
	end

	// Read data is captured on the rising edge that samples the read strobe, so it is valid the next cycle, and held.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end
	end

	// Checks.
	AST_RX_POWER_MAP: assert property (@(posedge clock) disable iff (!rst_n)
		wr_rx |=> converter_power_on == $past(reg_wdata[4])
			&& front_amp_power_on == $past(reg_wdata[0]))
		else $error("receive power bits not taken from the write");
	AST_AUX_POWER_MAP: assert property (@(posedge clock) disable iff (!rst_n)
		wr_aux |=> temperature_monitor_on == $past(reg_wdata[1])
			&& battery_monitor_on == $past(reg_wdata[0]))
		else $error("aux power bits not taken from the write");
	AST_CONV_SPLIT: assert property (@(posedge clock) disable iff (!rst_n)
		reg_rd && reg_addr == ADDR_CONV_LOW |=> reg_rdata[5:0] == 6'h00
			&& reg_rdata[7:6] == $past(conv_q[1:0]))
		else $error("converter low readback wrong");
	AST_CONV_HIGH: assert property (@(posedge clock) disable iff (!rst_n)
		reg_rd && reg_addr == ADDR_CONV_HIGH |=> reg_rdata == {2'b00, $past(conv_q[7:2])})
		else $error("converter high readback wrong");
	AST_TRIP_MAP: assert property (@(posedge clock) disable iff (!rst_n)
		wr_trip |=> battery_trip_code == $past(reg_wdata[4:0]))
		else $error("trip code not taken from the write");
	AST_BATT_ALARM: assert property (@(posedge clock) disable iff (!rst_n)
		below_now && !below_q |=> system_flags_q[BIT_BATT_ALARM])
		else $error("battery alarm flag not set");
	AST_EXT_OFF: assert property (@(posedge clock) disable iff (!rst_n)
		ext_ratio == 4'h0 ##1 ext_ratio == 4'h0 |-> !external_clock_out)
		else $error("external clock runs while disabled");
	AST_EXT_TOGGLE: assert property (@(posedge clock) disable iff (!rst_n)
		ext_ratio == 4'h1 ##1 ext_ratio == 4'h1 |-> external_clock_out != $past(external_clock_out))
		else $error("external clock does not toggle at ratio one");
	AST_GAIN_SPACING: assert property (@(posedge clock) disable iff (!rst_n)
		gain_update_tick && gain_div_q == 8'h01 && !wr_gain
			|=> !gain_update_tick [*8])
		else $error("gain tick too frequent");
	AST_GAIN_OFF: assert property (@(posedge clock) disable iff (!rst_n)
		gain_div_q == 8'h00 |=> !gain_update_tick)
		else $error("gain tick while divider is zero");
	AST_WAKE_COUNT: assert property (@(posedge clock) disable iff (!rst_n)
		wake_count >= wake_count_limit && !wake_reached_q |=> radio_flags_q[BIT_WAKE_COUNT])
		else $error("wake count flag not set");
	AST_STRENGTH: assert property (@(posedge clock) disable iff (!rst_n)
		smart_wake_active && smart_wake_strength > smart_wake_strength_limit
			&& !strength_over_q |=> radio_flags_q[BIT_SW_STRENGTH])
		else $error("smart wake strength flag not set");
	AST_CIPHER_GATE: assert property (@(posedge clock) disable iff (!rst_n)
		!radio_flags_q[BIT_CIPHER_DONE] && !cipher_loaded |=> !radio_flags_q[BIT_CIPHER_DONE])
		else $error("cipher done flagged without cipher firmware");
	AST_PACKET_GATE: assert property (@(posedge clock) disable iff (!rst_n)
		!radio_flags_q[BIT_TX_END] && !packet_mode |=> !radio_flags_q[BIT_TX_END])
		else $error("transmit end flagged outside packet mode");
	AST_ADDR_GATE: assert property (@(posedge clock) disable iff (!rst_n)
		!radio_flags_q[BIT_ADDR_MATCH] && !packet_mode |=> !radio_flags_q[BIT_ADDR_MATCH])
		else $error("address match flagged outside packet mode");
	AST_CRC_GATE: assert property (@(posedge clock) disable iff (!rst_n)
		!radio_flags_q[BIT_CRC_GOOD] && !packet_mode |=> !radio_flags_q[BIT_CRC_GOOD])
		else $error("good crc flagged outside packet mode");
	AST_SYNC_SET: assert property (@(posedge clock) disable iff (!rst_n)
		sync_seen |=> radio_flags_q[BIT_SYNC_SEEN])
		else $error("sync flag not set");
	AST_SET_WINS: assert property (@(posedge clock) disable iff (!rst_n)
		preamble_seen && wr_radio && reg_wdata[0] |=> radio_flags_q[BIT_PREAMBLE_SEEN])
		else $error("preamble event lost against a clear");
	AST_CMD_READY: assert property (@(posedge clock) disable iff (!rst_n)
		cmd_ready |=> system_flags_q[BIT_CMD_READY])
		else $error("command ready flag not set");
	AST_CMD_DONE: assert property (@(posedge clock) disable iff (!rst_n)
		cmd_finished |=> system_flags_q[BIT_CMD_DONE])
		else $error("command finished flag not set");
	AST_WAKE_TIMER: assert property (@(posedge clock) disable iff (!rst_n)
		wake_timer_expired |=> system_flags_q[BIT_WAKE_TIMER])
		else $error("wake timer flag not set");
	AST_UNUSED_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
		(system_flags_q & ~MASK_SYSTEM_FLAGS) == 8'h00)
		else $error("unused system flag bit set");
	AST_PORT_READY: assert property (@(posedge clock) disable iff (!rst_n)
		port_ready |=> system_flags_q[BIT_PORT_READY])
		else $error("port ready flag not set");
	AST_CAL_MAP: assert property (@(posedge clock) disable iff (!rst_n)
		wr_cal |=> synth_tune_enable == $past(reg_wdata[1])
			&& filter_tune_enable == $past(reg_wdata[0]))
		else $error("calibration enables not taken from the write");
	AST_CAL_STATUS: assert property (@(posedge clock) disable iff (!rst_n)
		$past(rst_n) |-> cal_ready_q[BIT_SYNTH_TUNE] == $past(synth_tune_done)
			&& cal_ready_q[BIT_RAMP_DONE] == $past(amp_ramp_done)
			&& cal_ready_q[7:3] == 5'h00)
		else $error("calibration status does not follow its sources");
	AST_FILTER_VALID: assert property (@(posedge clock) disable iff (!rst_n)
		!filter_tune_enable ##1 !filter_tune_enable |-> !cal_ready_q[BIT_FILTER_TUNE])
		else $error("filter tuning ready shown while disabled");
	AST_FLAG_STICKY: assert property (@(posedge clock) disable iff (!rst_n)
		system_flags_q[BIT_CMD_DONE] && !wr_system |=> system_flags_q[BIT_CMD_DONE])
		else $error("flag dropped without a host clear");
	AST_FLAG_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
		wr_radio && reg_wdata[BIT_SYNC_SEEN] && !sync_seen |=> !radio_flags_q[BIT_SYNC_SEEN])
		else $error("sync flag not cleared by a host write of one");

endmodule
